/* File: hw/drive_pkg.sv */
// Purpose: shared constants for the drive run/direction/acknowledge block
// Assumes: 40 MHz pclk, APB with 32-bit data
// Notes: register byte offsets, field positions, reset values, input indices
package drive_pkg;
  // clock and auto-acknowledge timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SEC_UNIT = 1;
  localparam int SEC_CYCLES = SEC_UNIT * CLK_HZ;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_ENSRC = 8'h04;
  localparam logic [7:0] OFS_AUTOACK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // field positions in the configuration word
  localparam int CFG_PROT_LSB = 0;
  localparam int CFG_DIR_LSB = 4;
  localparam int CFG_ACK_LSB = 9;
  // setting limits and reset values
  localparam logic [3:0] PROT_MAX = 4'h8;
  localparam logic [3:0] PROT_RST = 4'h1;
  localparam logic [4:0] DIR_MAX = 5'h10;
  localparam logic [4:0] DIR_RST = 5'h00;
  localparam logic [2:0] ACK_MAX = 3'h7;
  localparam logic [2:0] ACK_RST = 3'h4;
  localparam logic [4:0] ENSRC_MAX = 5'h12;
  localparam logic [4:0] ENSRC_AUTO = 5'h09;
  localparam logic [9:0] AUTOACK_MAX = 10'h3E8;
  // status bit positions
  localparam int ST_RUN = 0;
  localparam int ST_REV = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_KEYDIR = 3;
  localparam int ST_ARMED = 4;
  // synchronised input indices
  localparam int IN_W = 12;
  localparam int IN_DIN0 = 0;
  localparam int IN_AIN0 = 4;
  localparam int IN_KEY_REV = 6;
  localparam int IN_KEY_I = 7;
  localparam int IN_KEY_II = 8;
  localparam int IN_KEY_ACK = 9;
  localparam int IN_SW_EN = 10;
  localparam int IN_HW_EN = 11;
endpackage

/* File: hw/drive_qualify.sv */
// Purpose: start-up protection, direction select and fault acknowledge
// Assumes: APB slave, pclk 40 MHz, same-clock internal sources
// Notes: settings live in APB registers; outputs are registered
`timescale 1ns/1ps
module drive_qualify #(
  parameter int SEC_CYCLES = drive_pkg::SEC_CYCLES
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins and keypad keys
  input wire logic [3:0] din,
  input wire logic [1:0] ain_dig,
  input wire logic key_rev,
  input wire logic key_i,
  input wire logic key_ii,
  input wire logic key_ack,
  input wire logic ctrl_enable,
  input wire logic hw_enable,
  // internal same-clock sources
  input wire logic plc_prot,
  input wire logic plc_dir,
  input wire logic virt_out,
  input wire logic target_neg,
  input wire logic motor_running,
  input wire logic operational,
  input wire logic fault_cause,
  // qualified commands
  output logic run_cmd,
  output logic dir_rev,
  output logic fault_pending
);
  sync_if sy ();
  // settings
  logic [3:0] prot_sel; // start-up protection setting
  logic [4:0] dir_sel; // direction source setting
  logic [2:0] ack_sel; // acknowledge source setting
  logic [4:0] en_src; // enable source, only autostart is used here
  logic [9:0] autoack; // auto-acknowledge delay in seconds
  // internal state
  logic armed; // enable seen rising, protected or not; kept while enable stays high and no fault
  logic key_dir; // keypad-chosen direction, kept
  logic [25:0] pre_cnt; // one-second prescaler
  logic [9:0] sec_cnt; // elapsed whole seconds

  // synchronise pins and keys
  input_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({hw_enable, ctrl_enable, key_ack, key_ii, key_i, key_rev, ain_dig, din}),
    .out(sy.src)
  );

  // apb decode
  wire access = psel & penable & ~pready;
  wire wr = psel & penable & pready & pwrite;
  wire sel_cfg = paddr == drive_pkg::OFS_CFG;
  wire sel_en = paddr == drive_pkg::OFS_ENSRC;
  wire sel_aa = paddr == drive_pkg::OFS_AUTOACK;
  wire sel_st = paddr == drive_pkg::OFS_STATUS;
  wire mapped = sel_cfg | sel_en | sel_aa | sel_st;
  // fields of the write data
  wire [3:0] w_prot = pwdata[drive_pkg::CFG_PROT_LSB +: 4];
  wire [4:0] w_dir = pwdata[drive_pkg::CFG_DIR_LSB +: 5];
  wire [2:0] w_ack = pwdata[drive_pkg::CFG_ACK_LSB +: 3];
  wire [4:0] w_en = pwdata[4:0];
  wire [9:0] w_aa = pwdata[9:0];
  // read data
  wire [31:0] cfg_word = {20'h00000, ack_sel, dir_sel, prot_sel};
  wire [31:0] st_word = {27'h0000000, armed, key_dir, fault_pending, dir_rev, run_cmd};
  wire [31:0] rd_word = sel_cfg ? cfg_word
                      : sel_en ? {27'h0000000, en_src}
                      : sel_aa ? {22'h000000, autoack}
                      : sel_st ? st_word : 32'h00000000;

  // apb answer: one wait state, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access & ~mapped;
      prdata <= access & ~pwrite ? rd_word : 32'h00000000;
    end
  end

  // register writes; out-of-range values leave the field as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_sel <= drive_pkg::PROT_RST;
      dir_sel <= drive_pkg::DIR_RST;
      ack_sel <= drive_pkg::ACK_RST;
      en_src <= 5'h00;
      autoack <= 10'h000;
    end else if (wr) begin
      if (sel_cfg && w_prot <= drive_pkg::PROT_MAX) prot_sel <= w_prot;
      if (sel_cfg && w_dir <= drive_pkg::DIR_MAX) dir_sel <= w_dir;
      if (sel_cfg && w_ack <= drive_pkg::ACK_MAX) ack_sel <= w_ack;
      if (sel_en && w_en <= drive_pkg::ENSRC_MAX) en_src <= w_en;
      if (sel_aa && w_aa <= drive_pkg::AUTOACK_MAX) autoack <= w_aa;
    end
  end

  // start-up protection source
  wire [3:0] lv = sy.level[drive_pkg::IN_DIN0 +: 4];
  wire [1:0] av = sy.level[drive_pkg::IN_AIN0 +: 2];
  wire [3:0] lr = sy.rise[drive_pkg::IN_DIN0 +: 4];
  wire [1:0] ar = sy.rise[drive_pkg::IN_AIN0 +: 2];
  wire sw_en = sy.level[drive_pkg::IN_SW_EN];
  wire sw_rise = sy.rise[drive_pkg::IN_SW_EN];
  wire hw_en = sy.level[drive_pkg::IN_HW_EN];
  wire autostart = en_src == drive_pkg::ENSRC_AUTO;
  wire prot_din = prot_sel >= 4'h2 && prot_sel <= 4'h5 && lv[2'(prot_sel - 4'h2)];
  wire prot_plc = prot_sel == 4'h6 && plc_prot;
  wire prot_ain = prot_sel >= 4'h7 && av[1'(prot_sel - 4'h7)];
  wire prot_on = prot_sel == 4'h1 | prot_din | prot_plc | prot_ain;
  // run needs hardware enable, no fault, and, unless autostart, a fresh edge when protected
  wire sw_ok = autostart | sw_en & (armed | ~prot_on);
  wire next_run = hw_en & ~fault_pending & sw_ok;
  // arm on a rising enable; drop with enable or on a fault
  wire next_armed = ~fault_pending & sw_en & (armed | sw_rise);

  // keypad direction handling
  wire k_rev = sy.rise[drive_pkg::IN_KEY_REV];
  wire k_i = sy.rise[drive_pkg::IN_KEY_I];
  wire k_ii = sy.rise[drive_pkg::IN_KEY_II];
  wire tog_ok = dir_sel == 5'h0A & motor_running | dir_sel == 5'h0E & operational;
  wire two_key = dir_sel == 5'h0B | dir_sel == 5'h0F |
                 (dir_sel == 5'h0C | dir_sel == 5'h10) & ~motor_running;
  wire next_key_dir = tog_ok & k_rev ? ~key_dir
                    : two_key & k_ii ? 1'b1
                    : two_key & k_i ? 1'b0 : key_dir;
  wire keypad_mode = dir_sel >= 5'h0A && dir_sel != 5'h0D;
  // direction selection
  wire next_dir = dir_sel == 5'h00 ? target_neg
                : dir_sel == 5'h01 ? 1'b0
                : dir_sel == 5'h02 ? 1'b1
                : dir_sel <= 5'h06 ? lv[2'(dir_sel - 5'h03)]
                : dir_sel == 5'h07 ? plc_dir
                : dir_sel <= 5'h09 ? av[1'(dir_sel - 5'h08)]
                : dir_sel == 5'h0D ? virt_out
                : keypad_mode ? next_key_dir : dir_rev;

  // acknowledge source selection
  wire ack_din = ack_sel >= 3'h1 && ack_sel <= 3'h4 && lr[2'(ack_sel - 3'h1)];
  wire ack_key = ack_sel == 3'h5 && sy.rise[drive_pkg::IN_KEY_ACK];
  wire ack_ain = ack_sel >= 3'h6 && ar[1'(ack_sel - 3'h6)];
  wire ack_pulse = ack_din | ack_key | ack_ain;
  // auto-acknowledge timer runs only while fault is pending and its cause gone
  wire aa_run = fault_pending & ~fault_cause & autoack != 10'h000;
  wire sec_tick = pre_cnt == 26'(SEC_CYCLES - 1);
  wire aa_done = aa_run && sec_cnt == autoack;
  // a present cause wins over any clear
  wire next_fault = fault_cause | fault_pending & ~(ack_pulse | aa_done);

  // auto-acknowledge counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 26'h0000000;
      sec_cnt <= 10'h000;
    end else if (!aa_run || aa_done) begin
      pre_cnt <= 26'h0000000;
      sec_cnt <= 10'h000;
    end else begin
      pre_cnt <= sec_tick ? 26'h0000000 : pre_cnt + 26'h0000001;
      sec_cnt <= sec_tick ? sec_cnt + 10'h001 : sec_cnt;
    end
  end

  // command state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cmd <= 1'b0;
      armed <= 1'b0;
      dir_rev <= 1'b0;
      key_dir <= 1'b0;
      fault_pending <= 1'b0;
    end else begin
      run_cmd <= next_run;
      armed <= next_armed;
      dir_rev <= next_dir;
      key_dir <= next_key_dir;
      fault_pending <= next_fault;
    end
  end

  // checks
  prot_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    prot_sel <= drive_pkg::PROT_MAX && dir_sel <= drive_pkg::DIR_MAX && ack_sel <= drive_pkg::ACK_MAX)
    else $error("setting out of range");
  edge_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    prot_sel == 4'h1 && !autostart && !armed && !sw_rise |=> !run_cmd)
    else $error("start without enable edge");
  din_prot_a: assert property (@(posedge pclk) disable iff (!presetn)
    prot_sel == 4'h3 && lv[1] && !armed && !sw_rise && !autostart |=> !run_cmd)
    else $error("protected start on digital input");
  autostart_a: assert property (@(posedge pclk) disable iff (!presetn)
    autostart && hw_en && !fault_pending |=> run_cmd)
    else $error("autostart did not run");
  target_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_sel == 5'h00 |=> dir_rev == $past(target_neg))
    else $error("direction not from target sign");
  forced_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_sel == 5'h01 ##1 dir_sel == 5'h01 |-> !dir_rev)
    else $error("forced forwards broken");
  din_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_sel == 5'h04 |=> dir_rev == $past(lv[1]))
    else $error("direction not from digital input");
  rev_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_sel == 5'h0A && k_rev && motor_running |=> key_dir != $past(key_dir))
    else $error("reverse key did not toggle");
  still_key_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_sel == 5'h10 && motor_running |=> key_dir == $past(key_dir))
    else $error("key taken while running");
  ack_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_cause |=> fault_pending)
    else $error("fault cleared while cause present");
  no_manual_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_sel == 3'h0 && autoack == 10'h000 && fault_pending |=> fault_pending)
    else $error("fault cleared without source");
  din_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_sel == 3'h2 && lr[1] && fault_pending && !fault_cause |=> !fault_pending)
    else $error("digital acknowledge ignored");
  key_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_sel == 3'h5 && ack_key && fault_pending && !fault_cause |=> !fault_pending)
    else $error("keypad acknowledge ignored");
  // main scenarios
  edge_run_c: cover property (@(posedge pclk) disable iff (!presetn)
    prot_sel == 4'h1 && sw_rise ##[1:4] run_cmd);
  fault_ack_c: cover property (@(posedge pclk) disable iff (!presetn)
    fault_pending && ack_pulse ##1 !fault_pending);
  key_rev_c: cover property (@(posedge pclk) disable iff (!presetn)
    tog_ok && k_rev ##1 dir_rev);
  auto_ack_c: cover property (@(posedge pclk) disable iff (!presetn) aa_done);
endmodule

/* File: hw/input_sync.sv */
// Purpose: two-stage synchroniser and rising-edge detector per input
// Assumes: raw inputs come from pins or keys outside pclk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module input_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic [drive_pkg::IN_W-1:0] raw,
  // synchronised outputs
  sync_if.src out
);
  genvar i;
  // one synchroniser and edge detector per input bit
  generate
    for (i = 0; i < drive_pkg::IN_W; i++) begin : g_bit
      logic meta;
      logic stable;
      logic prev;
      // two flops, then a delayed copy for the edge
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // all stages start high so a pin already high at release gives no false edge
          meta <= 1'b1;
          stable <= 1'b1;
          prev <= 1'b1;
        end else begin
          meta <= raw[i];
          stable <= meta;
          prev <= stable;
        end
      end
      assign out.level[i] = stable;
      // edge from consecutive synchronised samples
      assign out.rise[i] = stable & ~prev;
      rise_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        out.rise[i] |=> !out.rise[i] && out.level[i] == $past(out.level[i]) || !out.rise[i])
        else $error("edge pulse longer than one cycle");
    end
  endgenerate
endmodule

/* File: hw/sync_if.sv */
// Purpose: carries synchronised input levels and rising-edge pulses
// Assumes: one pclk domain
// Notes: src drives, dst reads
`timescale 1ns/1ps
interface sync_if;
  // synchronised levels
  logic [drive_pkg::IN_W-1:0] level;
  // one-cycle rising-edge pulses
  logic [drive_pkg::IN_W-1:0] rise;
  modport src(output level, output rise);
  modport dst(input level, input rise);
endinterface

/* File: sim/pins_model.sv */
// Purpose: outside world of the drive block: terminal inputs and keypad keys
// Assumes: one line per synchroniser index of drive_pkg, changed right after pclk
// Notes: keys are pressed for several cycles, as a person would press them
`timescale 1ns/1ps
module pins_model (
  // clock
  input wire logic pclk,
  // terminal inputs
  output logic [3:0] din,
  output logic [1:0] ain_dig,
  // keypad keys
  output logic key_rev,
  output logic key_i,
  output logic key_ii,
  output logic key_ack,
  // enable pins
  output logic ctrl_enable,
  output logic hw_enable
);
  // line levels, indexed as the synchroniser inputs; both enables start high
  logic [drive_pkg::IN_W-1:0] st = 12'hC00;
  // fan the levels out to the pins
  assign din = st[3:0];
  assign ain_dig = st[5:4];
  assign key_rev = st[drive_pkg::IN_KEY_REV];
  assign key_i = st[drive_pkg::IN_KEY_I];
  assign key_ii = st[drive_pkg::IN_KEY_II];
  assign key_ack = st[drive_pkg::IN_KEY_ACK];
  assign ctrl_enable = st[drive_pkg::IN_SW_EN];
  assign hw_enable = st[drive_pkg::IN_HW_EN];
  // set one line just after a clock edge
  task automatic set(input int idx, input logic v);
    @(posedge pclk);
    st[idx] <= v;
  endtask
  // press and release; held long so a missing edge detector shows up
  task automatic pulse(input int idx);
    set(idx, 1'b1);
    repeat (6) @(posedge pclk);
    st[idx] <= 1'b0;
  endtask
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench for the drive run/direction/acknowledge block
// Assumes: APB with one wait state, SEC_CYCLES shortened to 8
// Notes: pins come from pins_model; internal sources are driven here
`timescale 1ns/1ps
module tb;
  // clock and reset
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  // apb
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // pins and internal sources
  logic [3:0] din;
  logic [1:0] ain_dig;
  logic key_rev, key_i, key_ii, key_ack, ctrl_enable, hw_enable;
  logic plc_prot = 0, plc_dir = 0, virt_out = 0, target_neg = 0, motor_running = 0, operational = 0;
  logic fault_cause = 0;
  logic run_cmd, dir_rev, fault_pending, err;
  // bookkeeping
  int mismatches = 0, check_count = 0, cycles = 0;
  int modes[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 13};
  drive_qualify #(.SEC_CYCLES(8)) drive_qualify_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din(din), .ain_dig(ain_dig), .key_rev(key_rev), .key_i(key_i), .key_ii(key_ii),
    .key_ack(key_ack), .ctrl_enable(ctrl_enable), .hw_enable(hw_enable), .plc_prot(plc_prot),
    .plc_dir(plc_dir), .virt_out(virt_out), .target_neg(target_neg), .motor_running(motor_running),
    .operational(operational), .fault_cause(fault_cause), .run_cmd(run_cmd), .dir_rev(dir_rev),
    .fault_pending(fault_pending));
  pins_model pins_model_inst (.pclk(pclk), .din(din), .ain_dig(ain_dig), .key_rev(key_rev), .key_i(key_i),
    .key_ii(key_ii), .key_ack(key_ack), .ctrl_enable(ctrl_enable), .hw_enable(hw_enable));
  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // counts and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare on a settled falling edge
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    @(negedge pclk);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // write the configuration word from its three fields
  task automatic cfg(input int p, input int d, input int a);
    apb(1'b1, drive_pkg::OFS_CFG, 32'(p << drive_pkg::CFG_PROT_LSB | d << drive_pkg::CFG_DIR_LSB
      | a << drive_pkg::CFG_ACK_LSB));
  endtask
  // drive every direction source of a mode to one level
  task automatic set_src(input int m, input logic v);
    @(posedge pclk);
    target_neg <= v;
    plc_dir <= v;
    virt_out <= v;
    if (m >= 3 && m <= 6) pins_model_inst.set(m - 3, v);
    if (m == 8 || m == 9) pins_model_inst.set(m - 4, v);
  endtask
  // one keypad press in a direction mode with a given motor state
  task automatic key_step(input int m, input logic r, input logic op, input int k, input logic e);
    cfg(1, m, 4);
    @(posedge pclk);
    motor_running <= r;
    operational <= op;
    pins_model_inst.pulse(k);
    idle(6);
    chk("dir_rev key", {31'h0, e}, {31'h0, dir_rev});
  endtask
  // raise and remove a fault cause
  task automatic fault();
    @(posedge pclk);
    fault_cause <= 1'b1;
    idle(3);
    fault_cause <= 1'b0;
  endtask
  initial begin
    idle(2);
    presetn <= 1'b1;
    apb(1'b0, drive_pkg::OFS_CFG, 32'h0);
    chk("cfg reset", 32'h0000_0801, rd);
    cfg(9, 0, 4);
    apb(1'b0, drive_pkg::OFS_CFG, 32'h0);
    chk("cfg prot above max", 32'h0000_0801, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped pslverr", 32'h1, {31'h0, err});
    chk("run with old enable", 32'h0, {31'h0, run_cmd});
    pins_model_inst.set(drive_pkg::IN_SW_EN, 1'b0);
    idle(6);
    pins_model_inst.set(drive_pkg::IN_SW_EN, 1'b1);
    idle(6);
    chk("run after enable edge", 32'h1, {31'h0, run_cmd});
    // logic-source protection: a fault drops the arming, enable stays high
    cfg(6, 0, 4);
    @(posedge pclk);
    plc_prot <= 1'b1;
    fault();
    idle(2);
    pins_model_inst.pulse(3);
    idle(6);
    chk("run protected by logic", 32'h0, {31'h0, run_cmd});
    @(posedge pclk);
    plc_prot <= 1'b0;
    idle(3);
    chk("run logic protection off", 32'h1, {31'h0, run_cmd});
    // fixed, level and target driven direction modes
    foreach (modes[i]) begin
      cfg(1, modes[i], 4);
      for (int v = 1; v >= 0; v--) begin
        set_src(modes[i], v[0]);
        idle(6);
        chk("dir_rev level", modes[i] == 1 ? 32'h0 : modes[i] == 2 ? 32'h1 : 32'(v), {31'h0, dir_rev});
      end
    end
    key_step(11, 1, 1, drive_pkg::IN_KEY_II, 1'b1);
    key_step(11, 1, 1, drive_pkg::IN_KEY_I, 1'b0);
    key_step(12, 1, 1, drive_pkg::IN_KEY_II, 1'b0);
    key_step(12, 0, 1, drive_pkg::IN_KEY_II, 1'b1);
    key_step(10, 0, 1, drive_pkg::IN_KEY_REV, 1'b1);
    key_step(10, 1, 1, drive_pkg::IN_KEY_REV, 1'b0);
    key_step(14, 1, 0, drive_pkg::IN_KEY_REV, 1'b0);
    key_step(14, 1, 1, drive_pkg::IN_KEY_REV, 1'b1);
    key_step(16, 1, 1, drive_pkg::IN_KEY_I, 1'b1);
    key_step(16, 0, 1, drive_pkg::IN_KEY_I, 1'b0);
    key_step(15, 1, 1, drive_pkg::IN_KEY_II, 1'b1);
    // acknowledge refused while the cause stays
    @(posedge pclk);
    fault_cause <= 1'b1;
    pins_model_inst.pulse(3);
    idle(6);
    chk("fault kept with cause", 32'h1, {31'h0, fault_pending});
    @(posedge pclk);
    fault_cause <= 1'b0;
    // every acknowledge source
    for (int s = 0; s <= 7; s++) begin
      cfg(1, 0, s);
      fault();
      idle(2);
      pins_model_inst.pulse(s == 5 ? drive_pkg::IN_KEY_ACK : s >= 6 ? s - 2 : s > 0 ? s - 1 : 3);
      idle(6);
      chk("fault after ack", 32'(s == 0), {31'h0, fault_pending});
    end
    // autostart ignores protection and the software enable
    apb(1'b1, drive_pkg::OFS_ENSRC, 32'h9);
    pins_model_inst.set(drive_pkg::IN_SW_EN, 1'b0);
    idle(6);
    chk("run autostart", 32'h1, {31'h0, run_cmd});
    pins_model_inst.set(drive_pkg::IN_HW_EN, 1'b0);
    idle(6);
    chk("run autostart no hw", 32'h0, {31'h0, run_cmd});
    // automatic clearing after two shortened seconds
    cfg(1, 0, 0);
    apb(1'b1, drive_pkg::OFS_AUTOACK, 32'h2);
    fault();
    idle(8);
    chk("fault before auto", 32'h1, {31'h0, fault_pending});
    idle(14);
    chk("fault after auto", 32'h0, {31'h0, fault_pending});
    // second reset in mid-run brings the settings and status back
    @(posedge pclk);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    apb(1'b0, drive_pkg::OFS_CFG, 32'h0);
    chk("cfg after second reset", 32'h0000_0801, rd);
    apb(1'b0, drive_pkg::OFS_STATUS, 32'h0);
    chk("status after second reset", 32'h0, rd);
    give_verdict();
  end
endmodule
